/* File: rtl/cwt_pkg.sv */
// constants, register map and field layout of the countdown watchdog
// assumes a 100 MHz system clock and a 32.768 kHz oscillator level input
// Functional notes
// R01 - control byte: repeat bit 7, count bits 6..2, step bits 1..0, reset zero
// R02 - step select 00=4 s, 01=1 s, 10=1/4 s, 11=1/16 s
// R03 - period equals loaded count times step; count 1 minimum, 31 maximum
// R04 - periods span 62.5 ms to 124 s over the four steps
// R05 - unsigned 5-bit counter decrements once per selected step
// R06 - writing a zero count halts the watchdog
// R07 - nonzero count write starts counting; software writes only 1 to 31
// R08 - count written mid-period replaces the running count at once
// R09 - first period may be one step off; later periods are exact
// R10 - reading the count field returns the live counter value
// R11 - software reads twice and accepts the count only when both agree
// R12 - repeat mode: flag set, counter reloaded, next period starts at once
// R13 - single shot: flag set at the end, counter stays at zero
// R14 - after single shot ends software writes a new count to rerun
// R15 - expired flag stays set until software clears it
// R16 - event reaches a pin only when that pin's enable bit is set
// R17 - pulse mode gives one pulse per period end, flag state aside
// R18 - level mode holds the pin active exactly while the flag is set
// R19 - every step tick is divided down from the oscillator
// R20 - register writes reach the counter with load and restart together
// R21 - end of period is a one-cycle strobe feeding flag and pulse logic
package cwt_pkg;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_IRQ_MODE = 8'h28;
    localparam logic [7:0] IDX_IRQ_A_EN = 8'h29;
    localparam logic [7:0] IDX_IRQ_B_EN = 8'h2A;
    localparam logic [7:0] IDX_FLAGS = 8'h2B;
    localparam logic [7:0] IDX_WD_CTRL = 8'h2D;
    localparam logic [1:0] BYTE_SHIFT = 2'h2;
    // bit positions inside the own registers
    localparam int unsigned WD_EN_BIT = 0;
    localparam int unsigned FLAG_BIT = 0;
    localparam int unsigned MODE_A_BIT = 0;
    localparam int unsigned MODE_B_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [4:0] COUNT_ZERO = 5'h00;
    localparam logic [4:0] COUNT_ONE = 5'h01;
    // step encodings
    localparam logic [1:0] STEP_4S = 2'h0;
    localparam logic [1:0] STEP_1S = 2'h1;
    localparam logic [1:0] STEP_QS = 2'h2;
    localparam logic [1:0] STEP_SS = 2'h3;
    // oscillator division
    localparam int unsigned OSC_HZ = 32768;
    localparam int unsigned PRE_W = 17;
    localparam logic [PRE_W-1:0] DIV_4S = PRE_W'(OSC_HZ * 4 - 1);
    localparam logic [PRE_W-1:0] DIV_1S = PRE_W'(OSC_HZ - 1);
    localparam logic [PRE_W-1:0] DIV_QS = PRE_W'(OSC_HZ / 4 - 1);
    localparam logic [PRE_W-1:0] DIV_SS = PRE_W'(OSC_HZ / 16 - 1);

    typedef struct packed {
        logic repeat_sel;
        logic [4:0] count;
        logic [1:0] step;
    } cwt_ctrl_s;
endpackage

/* File: rtl/cwt_step_div.sv */
// oscillator prescaler producing one step tick per selected step size
// assumes osc_i is a level already synchronous to clock_i
`timescale 1ns/10ps
`default_nettype none
module cwt_step_div (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic osc_i,
    input wire logic [1:0] step_i,
    output logic tick_o
);
    logic osc_q;
    logic [cwt_pkg::PRE_W-1:0] pre_q;
    logic [cwt_pkg::PRE_W-1:0] mask;
    wire osc_rise = osc_i & ~osc_q;

    // R02 R04 step decode
    assign mask = (step_i == cwt_pkg::STEP_4S) ? cwt_pkg::DIV_4S :
                  (step_i == cwt_pkg::STEP_1S) ? cwt_pkg::DIV_1S :
                  (step_i == cwt_pkg::STEP_QS) ? cwt_pkg::DIV_QS : cwt_pkg::DIV_SS;
    // R19 tick from oscillator
    assign tick_o = osc_rise & ((pre_q & mask) == mask);

    // R09 free running prescaler
    // never cleared by writes, so only the first period may be one step off
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            osc_q <= 1'b0;
            pre_q <= '0;
        end else begin
            osc_q <= osc_i;
            if (osc_rise) begin
                pre_q <= pre_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/cwt_watchdog.sv */
// countdown watchdog with classic wishbone register slave and two irq pins
// assumes osc_clk_i is synchronous to clock_i; irq pins active low
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module cwt_watchdog (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic osc_clk_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [cwt_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [cwt_pkg::DATA_W-1:0] wb_dat_i,
    output logic [cwt_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_out_a_n_o,
    output logic irq_out_b_n_o
);
    cwt_pkg::cwt_ctrl_s ctrl_q;
    logic [4:0] count_q;
    logic [4:0] count_d;
    logic expire_q;
    logic flag_q;
    logic en_a_q;
    logic en_b_q;
    logic pulse_a_q;
    logic pulse_b_q;
    logic ack_q;
    logic [cwt_pkg::DATA_W-1:0] dat_q;
    logic irq_a_n_q;
    logic irq_b_n_q;
    logic step_tick;

    wire req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr_lane = req & wb_we_i & wb_sel_i[0];
    wire [7:0] idx = wb_adr_i[9:2];
    wire hit_ctrl = idx == cwt_pkg::IDX_WD_CTRL;
    wire hit_flags = idx == cwt_pkg::IDX_FLAGS;
    wire hit_a = idx == cwt_pkg::IDX_IRQ_A_EN;
    wire hit_b = idx == cwt_pkg::IDX_IRQ_B_EN;
    wire hit_mode = idx == cwt_pkg::IDX_IRQ_MODE;
    wire wr_ctrl = wr_lane & hit_ctrl;
    wire clr_flag = wr_lane & hit_flags & wb_dat_i[cwt_pkg::FLAG_BIT];
    wire cwt_pkg::cwt_ctrl_s wr_val = cwt_pkg::cwt_ctrl_s'(wb_dat_i[7:0]);
    wire running = count_q != cwt_pkg::COUNT_ZERO;
    // R21 end of period strobe
    wire period_end = step_tick & (count_q == cwt_pkg::COUNT_ONE);

    // R19 oscillator divider
    cwt_step_div u_div (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .osc_i(osc_clk_i),
        .step_i(ctrl_q.step),
        .tick_o(step_tick)
    );

    // R10 live count on read
    wire [7:0] ctrl_rd = {ctrl_q.repeat_sel, count_q, ctrl_q.step};
    wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                         hit_flags ? {7'h00, flag_q} :
                         hit_a ? {7'h00, en_a_q} :
                         hit_b ? {7'h00, en_b_q} :
                         hit_mode ? {6'h00, pulse_b_q, pulse_a_q} : 8'h00;

    always_comb begin
        count_d = count_q;
        if (wr_ctrl) begin
            // R06 R07 R08 R20 write loads count and restarts at once
            count_d = wr_val.count;
        end else if (step_tick && running) begin
            if (period_end) begin
                // R12 R13 reload or stop at zero
                count_d = ctrl_q.repeat_sel ? ctrl_q.count : cwt_pkg::COUNT_ZERO;
            end else begin
                // R05 R03 step decrement
                count_d = count_q - cwt_pkg::COUNT_ONE;
            end
        end
    end

    // R01 control register
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl_q <= cwt_pkg::cwt_ctrl_s'(cwt_pkg::CTRL_RESET);
            count_q <= cwt_pkg::COUNT_ZERO;
        end else begin
            count_q <= count_d;
            if (wr_ctrl) begin
                ctrl_q <= wr_val;
            end
        end
    end

    // R15 sticky flag, set wins over clear
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            expire_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            expire_q <= period_end & ~wr_ctrl;
            flag_q <= expire_q | (flag_q & ~clr_flag);
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            en_a_q <= 1'b0;
            en_b_q <= 1'b0;
            pulse_a_q <= 1'b0;
            pulse_b_q <= 1'b0;
        end else begin
            if (wr_lane && hit_a) begin
                en_a_q <= wb_dat_i[cwt_pkg::WD_EN_BIT];
            end
            if (wr_lane && hit_b) begin
                en_b_q <= wb_dat_i[cwt_pkg::WD_EN_BIT];
            end
            if (wr_lane && hit_mode) begin
                pulse_a_q <= wb_dat_i[cwt_pkg::MODE_A_BIT];
                pulse_b_q <= wb_dat_i[cwt_pkg::MODE_B_BIT];
            end
        end
    end

    // R16 R17 R18 gated pulse or level
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_a_n_q <= 1'b1;
            irq_b_n_q <= 1'b1;
        end else begin
            irq_a_n_q <= ~(en_a_q & (pulse_a_q ? expire_q : flag_q));
            irq_b_n_q <= ~(en_b_q & (pulse_b_q ? expire_q : flag_q));
        end
    end

    // one wait state; unmapped reads give zero
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= req;
            if (req) begin
                dat_q <= {24'h000000, rd_byte};
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign irq_out_a_n_o = irq_a_n_q;
    assign irq_out_b_n_o = irq_b_n_q;
endmodule
`default_nettype wire

/* File: verif/cwt_props.sv */
// bus and pin assertions for the countdown watchdog
// assumes one clock domain; bound to every cwt_watchdog instance
`timescale 1ns/10ps
`default_nettype none
module cwt_props (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [cwt_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [cwt_pkg::DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_out_a_n_o,
    input wire logic irq_out_b_n_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic rdq = req && !wb_we_i;
    AST_ACK_NEXT: assert property (req |=> wb_ack_o)
        else $error("no ack after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    // a reset may clear the data, so skip the edge after it
    AST_DAT_HOLD: assert property (!wb_ack_o && !$past(rst_i) |-> $stable(wb_dat_o))
        else $error("read data moved between answers");
    AST_UNMAPPED: assert property (rdq && wb_adr_i < 32'hA0 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_FLAG_BITS: assert property (rdq && wb_adr_i == 32'hAC |=> wb_dat_o[7:1] == 7'h0)
        else $error("flags read sets unused bits");
    AST_RST_IDLE: assert property ($fell(rst_i) |-> irq_out_a_n_o && irq_out_b_n_o)
        else $error("pins active after reset");
endmodule
bind cwt_watchdog cwt_props cwt_props_i (.clock_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq_out_a_n_o, .irq_out_b_n_o);
`default_nettype wire

/* File: verif/test_countdown_watchdog_timer.sv */
// self-checking bench for the countdown watchdog
// assumes one step of the fastest size lasts 4096 cycles with osc at half rate
`timescale 1ns/10ps
`default_nettype none
module test_countdown_watchdog_timer;
    logic clock_i = 1'h0, rst_i = 1'h1, osc_clk_i = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = 4'hF;
    logic wb_ack_o, irq_out_a_n_o, irq_out_b_n_o;
    int fails = 0, n_tests = 0, cyc = 0;
    cwt_watchdog cwt_watchdog_i (.clock_i, .rst_i, .osc_clk_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_out_a_n_o,
        .irq_out_b_n_o);
    always #5 clock_i = ~clock_i;
    // fast oscillator keeps the run short
    always @(posedge clock_i) osc_clk_i <= ~osc_clk_i;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clock_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= {22'h0, idx, 2'h0};
        wb_dat_i <= {24'h0, d};
        do @(posedge clock_i); while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    task automatic fall_a(output int n);
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (irq_out_a_n_o !== 1'h0);
    endtask
    task automatic quiet_a;
        repeat (12288) begin
            @(posedge clock_i);
            if (irq_out_a_n_o !== 1'h1) chk("pin a quiet", 32'h0, 32'h1);
        end
    endtask
    task automatic t_repeat;
        int n;
        logic [31:0] first;
        wb(1'h0, 8'h2D, 8'h0);
        chk("ctrl reset", rd, 32'h0);
        wb(1'h0, 8'h10, 8'h0);
        chk("unmapped", rd, 32'h0);
        wb(1'h1, 8'h28, 8'h01);
        wb(1'h1, 8'h29, 8'h01);
        wb(1'h1, 8'h2A, 8'h01);
        wb(1'h1, 8'h2D, 8'h8B);
        fall_a(n);
        @(posedge clock_i);
        chk("pulse width", 32'(irq_out_a_n_o), 32'h1);
        chk("level pin", 32'(irq_out_b_n_o), 32'h0);
        fall_a(n);
        // two steps of 4096, less the cycle spent on the width check
        chk("period", n, 32'h1FFF);
        wb(1'h0, 8'h2D, 8'h0);
        chk("live reload", rd, 32'h8B);
        first = rd;
        wb(1'h0, 8'h2D, 8'h0);
        chk("double read", rd, first);
        wb(1'h0, 8'h2B, 8'h0);
        chk("flag set", rd, 32'h1);
        wb(1'h1, 8'h2B, 8'h01);
        wb(1'h0, 8'h2B, 8'h0);
        chk("flag clear", rd, 32'h0);
        chk("level off", 32'(irq_out_b_n_o), 32'h1);
        $display("done repeat test");
    endtask
    task automatic t_single;
        int n;
        wb(1'h1, 8'h2D, 8'h07);
        fall_a(n);
        wb(1'h0, 8'h2D, 8'h0);
        chk("stop at zero", rd, 32'h03);
        quiet_a();
        $display("done single shot test");
    endtask
    task automatic t_mask;
        wb(1'h1, 8'h2B, 8'h01);
        wb(1'h1, 8'h29, 8'h00);
        wb(1'h1, 8'h2D, 8'h87);
        quiet_a();
        chk("masked level", 32'(irq_out_b_n_o), 32'h0);
        wb(1'h1, 8'h2D, 8'h83);
        wb(1'h1, 8'h2B, 8'h01);
        wb(1'h1, 8'h29, 8'h01);
        quiet_a();
        wb(1'h0, 8'h2B, 8'h0);
        chk("halted", rd, 32'h0);
        $display("done mask and halt test");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 95000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge clock_i);
        rst_i <= 1'h0;
        t_repeat();
        t_single();
        t_mask();
        end_sim();
    end
endmodule
`default_nettype wire
